// file: hdl/pgcc_pkg.sv
// Package of constants and types for the packet generator and CRC checker block.
package pgcc_pkg;

    // ------------------------------------------------------------------
    // Register map.
    // ------------------------------------------------------------------
    localparam logic [4:0]  REG_GEN_CTRL  = 5'h10;
    localparam logic [4:0]  REG_CHK_CNT   = 5'h11;
    localparam logic [4:0]  REG_CHK_CTRL  = 5'h12;
    localparam logic [4:0]  REG_GEN_IPG   = 5'h13;
    localparam logic [4:0]  REG_SW_RESET  = 5'h14;
    localparam logic [4:0]  REG_IRQ_STAT  = 5'h15;
    localparam logic [4:0]  REG_IRQ_MASK  = 5'h16;

    // ------------------------------------------------------------------
    // Field positions and reset values.
    // ------------------------------------------------------------------
    localparam int          GEN_BURST_LSB = 8;
    localparam int          GEN_SEL_LSB   = 5;
    localparam int          GEN_TRIG_BIT  = 4;
    localparam int          GEN_HOLD_BIT  = 3;
    localparam int          GEN_PAY_BIT   = 2;
    localparam int          GEN_LEN_BIT   = 1;
    localparam int          GEN_ERR_BIT   = 0;
    localparam int          CHK_CLR_BIT   = 4;
    localparam int          SW_RESET_BIT  = 15;
    localparam logic [7:0]  IPG_RESET     = 8'h0C;
    localparam logic [7:0]  CNT_MAX       = 8'hFF;

    // Interface select codes shared by generator and checker.
    localparam logic [2:0]  SEL_NONE      = 3'h0;
    localparam logic [2:0]  SEL_COPPER    = 3'h2;
    localparam logic [2:0]  SEL_SERIAL    = 3'h4;
    localparam logic [2:0]  SEL_PARALLEL  = 3'h6;

    // ------------------------------------------------------------------
    // Frame constants.
    // ------------------------------------------------------------------
    localparam logic [10:0] LEN_SHORT     = 11'h040;
    localparam logic [10:0] LEN_LONG      = 11'h5EE;
    localparam logic [7:0]  PAT_A         = 8'h5A;
    localparam logic [7:0]  PAT_B         = 8'hA5;
    localparam logic [31:0] CRC_INIT      = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY_R    = 32'hEDB88320;
    localparam logic [31:0] CRC_RESIDUE   = 32'hDEBB20E3;
    localparam logic [15:0] LFSR_SEED     = 16'hACE1;

    // Generator states.
    typedef enum logic [2:0] {
        GS_IDLE = 3'b001,
        GS_DATA = 3'b010,
        GS_GAP  = 3'b100
    } pgcc_gstate_t;

endpackage

// file: hdl/pgcc_top.sv
// Packet generator and CRC checker self-test logic.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps

module pgcc_top (
    // Clock, reset and enable.
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        clkEn,
    // Register port.
    input  wire logic [4:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata,
    // Generated byte stream toward the selected interface.
    output logic      [7:0]  txData,
    output logic             txValid,
    output logic             txSymErr,
    output logic      [2:0]  txSel,
    // Received byte stream from the selected interface.
    input  wire logic [7:0]  rxData,
    input  wire logic        rxValid,
    input  wire logic [2:0]  rxSrc,
    // Interrupt.
    output logic             irq
);

    // ------------------------------------------------------------------
    // State record.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]            burst;
        logic [2:0]            genSel;
        logic                  done;
        logic                  hold;
        logic                  payPat;
        logic                  lenLong;
        logic                  errInj;
        logic [7:0]            ipg;
        logic [2:0]            chkSel;
        logic [7:0]            pktCnt;
        logic [7:0]            crcCnt;
        logic [1:0]            irqStat;
        logic [1:0]            irqMask;
        pgcc_pkg::pgcc_gstate_t gst;
        logic [10:0]           byteIdx;
        logic [7:0]            sent;
        logic [8:0]            gapCnt;
        logic [31:0]           txCrc;
        logic [15:0]           lfsr;
        logic [31:0]           rxCrc;
        logic                  rxBusy;
        logic [7:0]            txData;
        logic                  txValid;
        logic                  txSymErr;
        logic [15:0]           rdata;
    } pgcc_state_t;

    pgcc_state_t st_ff;
    pgcc_state_t nxt_st;

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------

    // One byte step of the reflected CRC-32 used for the frame check sequence.
    function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ pgcc_pkg::CRC_POLY_R) : (r >> 1);
        end
        return r;
    endfunction

    // True for the three documented interface codes.
    function automatic logic selValid(input logic [2:0] s);
        return (s == pgcc_pkg::SEL_COPPER) || (s == pgcc_pkg::SEL_SERIAL) ||
               (s == pgcc_pkg::SEL_PARALLEL);
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    logic [10:0] frameLen;
    logic [7:0]  payByte;
    logic [7:0]  fcsByte;
    logic [10:0] fcsOff;
    logic [31:0] fcs;
    logic        rxEnd;
    logic        rxMatch;
    logic        wrGen;
    logic        trigReq;
    logic        frameDoneEv;
    logic        runDoneEv;

    always_comb begin
        nxt_st      = st_ff;
        wrGen       = regWr && (regAddr == pgcc_pkg::REG_GEN_CTRL);
        frameLen    = st_ff.lenLong ? pgcc_pkg::LEN_LONG : pgcc_pkg::LEN_SHORT;
        payByte     = st_ff.payPat ? (st_ff.byteIdx[0] ? pgcc_pkg::PAT_B : pgcc_pkg::PAT_A)
                                   : st_ff.lfsr[7:0];
        fcs         = ~st_ff.txCrc ^ {31'h00000000, st_ff.errInj};
        // FCS bytes are picked by their distance from the frame end, because a long frame
        // does not start its FCS on a four-byte boundary.
        fcsOff      = st_ff.byteIdx - (frameLen - 11'h004);
        case (fcsOff[1:0])
            2'h0:    fcsByte = fcs[7:0];
            2'h1:    fcsByte = fcs[15:8];
            2'h2:    fcsByte = fcs[23:16];
            default: fcsByte = fcs[31:24];
        endcase
        frameDoneEv = 1'b0;
        runDoneEv   = 1'b0;
        trigReq     = 1'b0;
        rxEnd       = 1'b0;
        rxMatch     = 1'b0;

        // Free-running payload source, advanced on every enabled cycle.
        nxt_st.lfsr = {st_ff.lfsr[14:0], st_ff.lfsr[15] ^ st_ff.lfsr[13] ^ st_ff.lfsr[12] ^ st_ff.lfsr[10]};

        // Register writes. The trigger bit only acts while the run is done.
        if (wrGen) begin
            nxt_st.burst   = regWdata[pgcc_pkg::GEN_BURST_LSB +: 8];
            nxt_st.genSel  = regWdata[pgcc_pkg::GEN_SEL_LSB +: 3];
            nxt_st.hold    = regWdata[pgcc_pkg::GEN_HOLD_BIT];
            nxt_st.payPat  = regWdata[pgcc_pkg::GEN_PAY_BIT];
            nxt_st.lenLong = regWdata[pgcc_pkg::GEN_LEN_BIT];
            nxt_st.errInj  = regWdata[pgcc_pkg::GEN_ERR_BIT];
            trigReq = st_ff.done && !regWdata[pgcc_pkg::GEN_TRIG_BIT];
        end
        if (regWr && (regAddr == pgcc_pkg::REG_GEN_IPG)) begin
            nxt_st.ipg = regWdata[7:0];
        end
        if (regWr && (regAddr == pgcc_pkg::REG_CHK_CTRL)) begin
            nxt_st.chkSel = regWdata[2:0];
        end
        if (regWr && (regAddr == pgcc_pkg::REG_IRQ_MASK)) begin
            nxt_st.irqMask = regWdata[1:0];
        end
        if (regWr && (regAddr == pgcc_pkg::REG_IRQ_STAT)) begin
            nxt_st.irqStat = st_ff.irqStat & ~regWdata[1:0];
        end

        // Generator sequencer: frame bytes, then FCS, then the gap.
        case (st_ff.gst)
            pgcc_pkg::GS_IDLE: begin
                nxt_st.txValid  = 1'b0;
                nxt_st.txSymErr = 1'b0;
                // A new configuration write that starts a run also counts as a trigger.
                if (wrGen && selValid(regWdata[pgcc_pkg::GEN_SEL_LSB +: 3]) && !st_ff.done) begin
                    trigReq = 1'b1;
                end
                if (trigReq && selValid(nxt_st.genSel) && nxt_st.hold
                    && (nxt_st.burst != 8'h00)) begin
                    nxt_st.done    = 1'b0;
                    nxt_st.gst     = pgcc_pkg::GS_DATA;
                    nxt_st.byteIdx = 11'h000;
                    nxt_st.sent    = 8'h00;
                    nxt_st.txCrc   = pgcc_pkg::CRC_INIT;
                end else if (wrGen && selValid(regWdata[pgcc_pkg::GEN_SEL_LSB +: 3])
                             && !regWdata[pgcc_pkg::GEN_HOLD_BIT]) begin
                    // Self-clearing mode runs as soon as an interface is chosen.
                    nxt_st.done    = 1'b0;
                    nxt_st.gst     = pgcc_pkg::GS_DATA;
                    nxt_st.byteIdx = 11'h000;
                    nxt_st.sent    = 8'h00;
                    nxt_st.txCrc   = pgcc_pkg::CRC_INIT;
                end
            end
            pgcc_pkg::GS_DATA: begin
                nxt_st.txValid  = 1'b1;
                nxt_st.txSymErr = 1'b0;
                nxt_st.byteIdx  = st_ff.byteIdx + 11'h001;
                if (st_ff.byteIdx < frameLen - 11'h004) begin
                    nxt_st.txData = payByte;
                    nxt_st.txCrc  = crcByte(st_ff.txCrc, payByte);
                end else begin
                    nxt_st.txData = fcsByte;
                    // Symbol error is flagged on the last FCS byte of an errored frame.
                    nxt_st.txSymErr = st_ff.errInj && (st_ff.byteIdx == frameLen - 11'h001);
                end
                if (st_ff.byteIdx == frameLen - 11'h001) begin
                    nxt_st.gst    = pgcc_pkg::GS_GAP;
                    nxt_st.gapCnt = {1'b0, st_ff.ipg} + 9'h001;
                    frameDoneEv   = 1'b1;
                    if (st_ff.burst != 8'h00) begin
                        nxt_st.sent = st_ff.sent + 8'h01;
                    end
                end
            end
            pgcc_pkg::GS_GAP: begin
                nxt_st.txValid  = 1'b0;
                nxt_st.txSymErr = 1'b0;
                nxt_st.gapCnt   = st_ff.gapCnt - 9'h001;
                if (st_ff.gapCnt <= 9'h001) begin
                    if ((st_ff.burst != 8'h00) && (st_ff.sent >= st_ff.burst)) begin
                        nxt_st.gst  = pgcc_pkg::GS_IDLE;
                        nxt_st.done = 1'b1;
                        runDoneEv   = 1'b1;
                        if (!st_ff.hold) begin
                            nxt_st.genSel = pgcc_pkg::SEL_NONE;
                        end
                    end else if (st_ff.genSel == pgcc_pkg::SEL_NONE) begin
                        nxt_st.gst  = pgcc_pkg::GS_IDLE;
                        nxt_st.done = 1'b1;
                    end else begin
                        nxt_st.gst     = pgcc_pkg::GS_DATA;
                        nxt_st.byteIdx = 11'h000;
                        nxt_st.txCrc   = pgcc_pkg::CRC_INIT;
                    end
                end
            end
            default: begin
                nxt_st.gst = pgcc_pkg::GS_IDLE;
            end
        endcase

        // Checker: fold bytes into the CRC and close the frame when valid drops.
        if (rxValid && (rxSrc == st_ff.chkSel) && selValid(st_ff.chkSel)) begin
            nxt_st.rxCrc  = crcByte(st_ff.rxBusy ? st_ff.rxCrc : pgcc_pkg::CRC_INIT, rxData);
            nxt_st.rxBusy = 1'b1;
        end else if (st_ff.rxBusy) begin
            nxt_st.rxBusy = 1'b0;
            rxEnd         = 1'b1;
            rxMatch       = (st_ff.rxCrc == pgcc_pkg::CRC_RESIDUE);
        end
        if (rxEnd) begin
            if (st_ff.pktCnt != pgcc_pkg::CNT_MAX) begin
                nxt_st.pktCnt = st_ff.pktCnt + 8'h01;
            end
            if (!rxMatch && (st_ff.crcCnt != pgcc_pkg::CNT_MAX)) begin
                nxt_st.crcCnt = st_ff.crcCnt + 8'h01;
            end
        end
        if ((regWr && (regAddr == pgcc_pkg::REG_CHK_CTRL) && regWdata[pgcc_pkg::CHK_CLR_BIT])
            || (nxt_st.chkSel == pgcc_pkg::SEL_NONE)) begin
            nxt_st.pktCnt = 8'h00;
            nxt_st.crcCnt = 8'h00;
            nxt_st.rxBusy = 1'b0;
        end

        // Sticky events: set wins over a same-cycle clear.
        nxt_st.irqStat = nxt_st.irqStat | {runDoneEv, rxEnd && !rxMatch};

        // Read data, valid only in the cycle after the strobe.
        nxt_st.rdata = 16'h0000;
        if (regRd) begin
            case (regAddr)
                pgcc_pkg::REG_GEN_CTRL: nxt_st.rdata = {st_ff.burst, st_ff.genSel, st_ff.done,
                                                         st_ff.hold, st_ff.payPat, st_ff.lenLong,
                                                         st_ff.errInj};
                pgcc_pkg::REG_CHK_CNT:  nxt_st.rdata = {st_ff.pktCnt, st_ff.crcCnt};
                pgcc_pkg::REG_CHK_CTRL: nxt_st.rdata = {13'h0000, st_ff.chkSel};
                pgcc_pkg::REG_GEN_IPG:  nxt_st.rdata = {8'h00, st_ff.ipg};
                pgcc_pkg::REG_IRQ_STAT: nxt_st.rdata = {14'h0000, st_ff.irqStat};
                pgcc_pkg::REG_IRQ_MASK: nxt_st.rdata = {14'h0000, st_ff.irqMask};
                default:                nxt_st.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------

    // Hard reset and the software reset bit both return every field to its default.
    // The software reset bit reads back zero because its address is not decoded for reads.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_ff          <= '0;
            st_ff.gst      <= pgcc_pkg::GS_IDLE;
            st_ff.ipg      <= pgcc_pkg::IPG_RESET;
            st_ff.lfsr     <= pgcc_pkg::LFSR_SEED;
            st_ff.done     <= 1'b1;
        end else if (clkEn) begin
            if (regWr && (regAddr == pgcc_pkg::REG_SW_RESET) && regWdata[pgcc_pkg::SW_RESET_BIT]) begin
                st_ff      <= '0;
                st_ff.gst  <= pgcc_pkg::GS_IDLE;
                st_ff.ipg  <= pgcc_pkg::IPG_RESET;
                st_ff.lfsr <= pgcc_pkg::LFSR_SEED;
                st_ff.done <= 1'b1;
            end else begin
                st_ff      <= nxt_st;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign regRdata = st_ff.rdata;
    assign txData   = st_ff.txData;
    assign txValid  = st_ff.txValid;
    assign txSymErr = st_ff.txSymErr;
    assign txSel    = st_ff.genSel;
    assign irq      = |(st_ff.irqStat & st_ff.irqMask);

endmodule

// file: test/pgcc_monitor.sv
// Concurrent checks on the ports of the packet generator and CRC checker.
`timescale 1ns/100ps

module pgcc_monitor (
    // Clock, reset and enable.
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        clkEn,
    // Register port.
    input wire logic [4:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdata,
    // Streams and interrupt.
    input wire logic [7:0]  txData,
    input wire logic        txValid,
    input wire logic        txSymErr,
    input wire logic [2:0]  txSel,
    input wire logic [7:0]  rxData,
    input wire logic        rxValid,
    input wire logic [2:0]  rxSrc,
    input wire logic        irq
);
    // ------------------------------------------------------------------
    // Shadow fields and run lengths.
    // ------------------------------------------------------------------
    logic [10:0] runLen_ff;
    logic [8:0]  gapLen_ff;
    logic [7:0]  ipgSh_ff;
    logic [2:0]  chkSh_ff;
    logic        wrOk;
    logic        swRst;

    // Soft reset truncates a frame legally, so the length check skips it.
    assign wrOk  = regWr && clkEn;
    assign swRst = wrOk && regAddr == pgcc_pkg::REG_SW_RESET && regWdata[pgcc_pkg::SW_RESET_BIT];

    // The gap counter saturates so that long idle spells never wrap.
    always_ff @(posedge clock) begin
        if (!rstn || swRst) begin
            ipgSh_ff <= pgcc_pkg::IPG_RESET;
            chkSh_ff <= pgcc_pkg::SEL_NONE;
        end else if (wrOk && regAddr == pgcc_pkg::REG_GEN_IPG) begin
            ipgSh_ff <= regWdata[7:0];
        end else if (wrOk && regAddr == pgcc_pkg::REG_CHK_CTRL) begin
            chkSh_ff <= regWdata[2:0];
        end
        runLen_ff <= (!rstn || !txValid) ? 11'h000 : runLen_ff + 11'h001;
        gapLen_ff <= (!rstn || txValid) ? 9'h000 : gapLen_ff + {8'h00, gapLen_ff != 9'h1FF};
    end

    default clocking mcb @(posedge clock); endclocking
    default disable iff (!rstn);

    // Frames go out only on a valid interface, which holds during a frame.
    sel_legal_a: assert property (txValid |-> txSel inside {3'h2, 3'h4, 3'h6})
        else $error("frame on a reserved interface");
    sel_steady_a: assert property (txValid && $past(txValid) |-> $stable(txSel))
        else $error("interface changed inside a frame");
    frame_len_a: assert property ($fell(txValid) && !$past(swRst) && !$past(swRst, 2)
        |-> runLen_ff == pgcc_pkg::LEN_SHORT || runLen_ff == pgcc_pkg::LEN_LONG) else $error("bad frame length");
    sym_last_a: assert property (txSymErr |-> txValid ##1 !txValid)
        else $error("symbol error not on last byte");
    gap_min_a: assert property ($rose(txValid) |-> gapLen_ff >= {1'b0, ipgSh_ff} + 9'h001)
        else $error("gap shorter than programmed");
    busy_reads_a: assert property (regRd && clkEn && regAddr == 5'h10 && txValid
        |=> !regRdata[pgcc_pkg::GEN_TRIG_BIT]) else $error("done read during transmit");
    cnt_clear_a: assert property (wrOk && regAddr == 5'h12 && regWdata[pgcc_pkg::CHK_CLR_BIT]
        ##[1:3] regRd && regAddr == 5'h11 && !rxValid |=> regRdata == 16'h0000) else $error("counters not cleared");
    off_reads_a: assert property (regRd && clkEn && regAddr == 5'h11 && chkSh_ff == 3'h0
        |=> regRdata == 16'h0000) else $error("counters nonzero while checker off");
    irq_masked_a: assert property (wrOk && regAddr == pgcc_pkg::REG_IRQ_MASK && regWdata[1:0] == 2'b00
        |=> !irq) else $error("interrupt with all sources masked");

    // Main scenarios reached.
    cover property ($fell(txValid) && runLen_ff == pgcc_pkg::LEN_LONG);
    cover property (txSymErr);
    cover property ($rose(irq));
endmodule

bind pgcc_top pgcc_monitor u_mon (.clock(clock), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .txData(txData),
    .txValid(txValid), .txSymErr(txSymErr), .txSel(txSel), .rxData(rxData), .rxValid(rxValid),
    .rxSrc(rxSrc), .irq(irq));

// file: test/pgcc_partner.sv
// Far-side model that loops the generated stream back into the checker.
`timescale 1ns/100ps

module pgcc_partner (
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       rstn,
    // Stream from the generator.
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    input  wire logic [2:0] txSel,
    // Stream toward the checker.
    output logic      [7:0] rxData,
    output logic            rxValid,
    output logic      [2:0] rxSrc
);
    // Bytes return one cycle late; idle data shows the inverse so stale bytes never look valid.
    always @(posedge clock) begin
        rxValid <= rstn && txValid;
        rxData  <= txValid ? txData : ~rxData;
        rxSrc   <= txSel;
    end
endmodule

// file: test/packet_generator_crc_checker_tb.sv
// Self-checking bench for the packet generator and CRC checker.
`timescale 1ns/100ps

module packet_generator_crc_checker_tb;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        clkEn = 1'b1;
    logic [4:0]  regAddr = 5'h00;
    logic [15:0] regWdata = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [15:0] regRdata;
    logic [7:0]  txData, rxData;
    logic        txValid, txSymErr, rxValid, irq;
    logic [2:0]  txSel, rxSrc, lastSel;
    logic [15:0] v;
    logic        patOn = 1'b0;
    logic        prevV = 1'b0;
    int          err_count = 0;
    int          checks = 0;
    int          frames = 0, lastLen = 0, lastGap = 0, gapCnt = 0, curLen = 0, symCnt = 0, patBad = 0, f0;

    always #50 clock = ~clock;

    pgcc_top DUT (.clock(clock), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .txData(txData), .txValid(txValid),
        .txSymErr(txSymErr), .txSel(txSel), .rxData(rxData), .rxValid(rxValid), .rxSrc(rxSrc), .irq(irq));
    pgcc_partner u_far (.clock(clock), .rstn(rstn), .txData(txData), .txValid(txValid), .txSel(txSel),
        .rxData(rxData), .rxValid(rxValid), .rxSrc(rxSrc));

    // ------------------------------------------------------------------
    // Frame observer, on the falling edge where outputs have settled.
    // ------------------------------------------------------------------
    always @(negedge clock) begin
        if (txValid === 1'b1) begin
            if (!prevV) lastGap = gapCnt;
            if (!prevV) curLen = 0;
            if (patOn && curLen < 60 && txData !== (curLen[0] ? 8'hA5 : 8'h5A)) patBad++;
            lastSel = txSel;
            curLen++;
        end else begin
            if (prevV) frames++;
            if (prevV) lastLen = curLen;
            if (prevV) gapCnt = 0;
            gapCnt++;
        end
        if (txSymErr === 1'b1) symCnt++;
        prevV = (txValid === 1'b1);
    end

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock); regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge clock); regWr <= 1'b0;
    endtask
    task automatic rdv(input logic [4:0] a, output logic [15:0] d);
        @(posedge clock); regAddr <= a; regRd <= 1'b1;
        @(posedge clock); regRd <= 1'b0;
        @(negedge clock); d = regRdata;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        rdv(a, v);
        check(v, exp);
    endtask
    // Polls the done flag with a bound so a stuck run cannot hang the bench.
    task automatic waitDone(input int n);
        for (int i = 0; i < n; i++) begin
            rdv(5'h10, v);
            if (v[pgcc_pkg::GEN_TRIG_BIT] === 1'b1) break;
        end
        check({15'h0, v[pgcc_pkg::GEN_TRIG_BIT]}, 16'h0001);
    endtask
    task automatic irqIs(input logic e);
        @(negedge clock); check({15'h0, irq}, {15'h0, e});
    endtask
    task automatic print_verdict;
        $display("mismatches=%0d comparisons=%0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(5'h10, 16'h0010);
        rd(5'h11, 16'h0000);
        rd(pgcc_pkg::REG_GEN_IPG, 16'h000C);
        rd(5'h1F, 16'h0000);
    endtask
    task automatic t_cont;
        wr(5'h12, 16'h0002); wr(5'h10, 16'h0040); f0 = frames;
        for (int i = 0; i < 2000 && frames < f0 + 3; i++) @(negedge clock);
        check(16'(frames - f0), 16'h0003);
        wr(pgcc_pkg::REG_SW_RESET, 16'h8000); f0 = frames;
        repeat (300) @(negedge clock);
        check(16'(frames - f0), 16'h0000);
        rd(5'h10, 16'h0010);
        rd(5'h12, 16'h0000);
        rd(5'h11, 16'h0000);
    endtask
    // Burst of two patterned frames, with a write during the run that sets the trigger bit to 1, a value that never requests a trigger.
    task automatic t_burst;
        patOn = 1'b1; wr(5'h12, 16'h0002); wr(pgcc_pkg::REG_GEN_IPG, 16'h0003); wr(pgcc_pkg::REG_IRQ_MASK, 16'h0002);
        f0 = frames; wr(5'h10, 16'h024C);
        rd(5'h10, 16'h024C);
        wr(5'h10, 16'h025C); waitDone(300);
        check(16'(frames - f0), 16'h0002);
        check(16'(lastLen), 16'h0040);
        check(16'(lastGap), 16'h0004);
        check(16'(patBad), 16'h0000);
        rd(5'h10, 16'h025C);
        rd(5'h11, 16'h0200);
        irqIs(1'b1); wr(pgcc_pkg::REG_IRQ_STAT, 16'h0002); irqIs(1'b0);
    endtask
    task automatic t_restart;
        f0 = frames; wr(5'h10, 16'h024C); waitDone(300);
        check(16'(frames - f0), 16'h0002);
        rd(5'h11, 16'h0400);
    endtask
    task automatic t_error;
        patOn = 1'b0; f0 = symCnt; wr(pgcc_pkg::REG_IRQ_MASK, 16'h0001);
        wr(5'h10, 16'h0141); waitDone(300);
        rd(5'h10, 16'h0111);
        check(16'(symCnt - f0), 16'h0001);
        rd(5'h11, 16'h0501);
        irqIs(1'b1); wr(pgcc_pkg::REG_IRQ_STAT, 16'h0001); irqIs(1'b0);
        wr(pgcc_pkg::REG_IRQ_MASK, 16'h0000);
    endtask
    task automatic t_long;
        wr(5'h10, 16'h014A); waitDone(2000);
        check(16'(lastLen), 16'h05EE);
        rd(5'h11, 16'h0601);
    endtask
    task automatic t_clear;
        wr(5'h12, 16'h0012);
        rd(5'h11, 16'h0000);
        rd(5'h12, 16'h0002);
        // A write while the enable is low must leave the gap register untouched.
        @(posedge clock); clkEn <= 1'b0;
        wr(pgcc_pkg::REG_GEN_IPG, 16'h0055); clkEn <= 1'b1;
        rd(pgcc_pkg::REG_GEN_IPG, 16'h0003);
    endtask
    task automatic t_refuse;
        f0 = frames; wr(5'h10, 16'h01A8); repeat (40) @(negedge clock);
        wr(5'h10, 16'h0048); repeat (40) @(negedge clock);
        check(16'(frames - f0), 16'h0000);
        wr(5'h10, 16'h0000);
    endtask
    task automatic t_sat;
        wr(pgcc_pkg::REG_GEN_IPG, 16'h0000); f0 = frames; wr(5'h10, 16'hFF48); waitDone(12000);
        check(16'(frames - f0), 16'h00FF);
        rd(5'h11, 16'hFF00);
        wr(5'h10, 16'h0148); waitDone(300);
        rd(5'h11, 16'hFF00);
    endtask
    // Generator and checker codes paired; a mismatched pair must not count.
    task automatic t_sel;
        logic [2:0] g[3] = '{3'h4, 3'h6, 3'h2};
        logic [2:0] c[3] = '{3'h4, 3'h6, 3'h6};
        for (int i = 0; i < 3; i++) begin
            wr(5'h12, {12'h001, 1'b0, c[i]}); wr(5'h10, {8'h01, g[i], 5'h08}); waitDone(300);
            check({13'h0, lastSel}, {13'h0, g[i]});
            rd(5'h11, {7'h00, g[i] == c[i], 8'h00});
        end
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (20) @(posedge clock);
        t_reset; t_cont; t_burst; t_restart; t_error; t_long; t_clear; t_refuse; t_sat; t_sel;
        print_verdict;
    end

    // Watchdog sized well beyond the longest expected run.
    initial begin
        #6000000;
        err_count++;
        print_verdict;
    end
endmodule
